// ### shared/dcr_defines.vh
// Constants for the disk configuration response block.
// Assumes inclusion by bare name from logic files.
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH

// APB register byte offsets
`define DCR_OFF_CMD        12'h000
`define DCR_OFF_RESP       12'h004
`define DCR_OFF_STATUS     12'h008
`define DCR_OFF_RATE_HZ    12'h00c
`define DCR_OFF_SKEW       12'h010
`define DCR_OFF_DELAYS     12'h014
`define DCR_OFF_SPLICE     12'h018
`define DCR_OFF_CYL        12'h01c
`define DCR_OFF_HEADS      12'h020
`define DCR_OFF_GAP_SYNC   12'h024
`define DCR_OFF_STWORDS    12'h028
`define DCR_OFF_SEEKSKEW   12'h02c
`define DCR_OFF_SECT       12'h030
`define DCR_OFF_VENDOR     12'h034

// Command word fields
`define DCR_MOD_HI         11
`define DCR_MOD_LO         8
`define DCR_SUB_HI         7
`define DCR_SUB_LO         0

// Modifier codes
`define DCR_MOD_GENERAL    4'h0
`define DCR_MOD_FIX_CYL    4'h1
`define DCR_MOD_REM_CYL    4'h2
`define DCR_MOD_HEADS      4'h3
`define DCR_MOD_UNF_BYTES  4'h4
`define DCR_MOD_SECTORS    4'h5
`define DCR_MOD_SIX        4'h6
`define DCR_MOD_GAP        4'h7
`define DCR_MOD_SYNC       4'h8
`define DCR_MOD_STWORDS    4'h9
`define DCR_MOD_SEEKSKEW   4'he
`define DCR_MOD_VENDOR     4'hf

// Subscripts under modifier 0000
`define DCR_SUB_RATE       8'h08
`define DCR_SUB_GRPSKEW    8'h0a
`define DCR_SUB_DELAYS     8'h0b
`define DCR_SUB_MARKSKEW   8'h0c
`define DCR_SUB_SPLICE     8'h0d

// Reset values
`define DCR_RST_RATE_HZ    32'h00000000
`define DCR_RST_WORD       32'h00000000

// Rate conversion: Hz per kHz
`define DCR_HZ_PER_KHZ     32'd1000
// Link clock: high speed port tops at 24 MHz
`define DCR_RATE_MAX_HZ    32'd24000000
// High speed port floor and low speed port ceiling
`define DCR_RATE_MIN_HS_HZ 32'd10000000
`define DCR_RATE_MAX_LS_HZ 32'd15000000

`endif

// ### logic/dcr_config_resp.v
// Disk drive Request Configuration responder with APB register file.
// Assumes an APB master on clk, and a command strobe/clock from the link
// side that is asynchronous and passes a two-flop synchroniser here.
//
// What this block does
// - Modifier 0000, subscript 8 returns nominal clock frequency in kilohertz
// - Fractional kilohertz transfer rate rounds up to next integer
// - Rate response mandatory with high speed port; range 0-15 or 10-24 MHz
// - Head group skew reported as modulo-256 fraction of rotation
// - Read gate window after splice in bits, zero means default applies
// - Write splice size in bits from write gate to stable channel
// - Read propagation delay in bits from media to read clock
// - Write data delay in bits from write clock latch to media
// - Mark detection skew in bits for index, sector, address mark
// - Modifiers 1-9, 14, 15 give specific words, 10-13 return zero; 1 fixed, 2 removable cylinders
// - Modifier 0011: removable heads high byte, fixed heads low byte
// - Modifier 0111 upper byte holds inter-sector gap byte count
// - Modifier 1000: upper byte zero, lower byte sync bytes needed
// - Modifier 1001: extended status words high, vendor words low
// - Modifier 1110: cylinder switch skew high, head switch skew low
// - Subscripts 11, 12, 13 carry delays, mark skew, window and splice
// - Subscript 10 returns head group skew low byte, upper zero
//
// The register addresses and the APB register port were decided locally.
`include "dcr_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module dcr_config_resp #(
   parameter HIGH_SPEED = 1'b1
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Link command: strobe rising edge latches cmd_word
   input  wire        cmd_strobe,
   input  wire [15:0] cmd_word,
   // Link answer
   output reg  [15:0] resp_word,
   output reg         resp_valid,
   output reg         rate_supported
);

   ////////////////////////////////////////////////////////////////////
   // Software-loaded configuration values
   reg [31:0] rate_hz_r;
   reg [15:0] skew_r;       // [7:0] head group skew
   reg [15:0] delays_r;     // read delay, write delay
   reg [15:0] mark_skew_r;  // [7:0] mark skew
   reg [15:0] splice_r;     // window, splice size
   reg [31:0] cyl_r;        // [31:16] removable, [15:0] fixed
   reg [15:0] heads_r;
   reg [15:0] gap_sync_r;   // [15:8] gap bytes, [7:0] sync bytes
   reg [15:0] stwords_r;
   reg [15:0] seekskew_r;
   reg [31:0] sect_r;       // [31:16] sectors, [15:0] unformatted bytes
   reg [15:0] vendor_r;
   reg [15:0] mod6_r;
   reg [31:0] cmd_r;
   reg [15:0] resp_nxt;

   wire apb_acc = psel & penable;
   wire apb_wr  = apb_acc & pwrite;

   ////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_hz_r  <= `DCR_RST_RATE_HZ;
         skew_r     <= 16'h0000;
         delays_r   <= 16'h0000;
         mark_skew_r <= 16'h0000;
         splice_r   <= 16'h0000;
         cyl_r      <= `DCR_RST_WORD;
         heads_r    <= 16'h0000;
         gap_sync_r <= 16'h0000;
         stwords_r  <= 16'h0000;
         seekskew_r <= 16'h0000;
         sect_r     <= `DCR_RST_WORD;
         vendor_r   <= 16'h0000;
         mod6_r     <= 16'h0000;
      end else if (apb_wr) begin
         case (paddr)
            `DCR_OFF_RATE_HZ:  rate_hz_r  <= pwdata;
            `DCR_OFF_SKEW: begin
               skew_r      <= {8'h00, pwdata[7:0]};
               mark_skew_r <= {8'h00, pwdata[23:16]};
            end
            `DCR_OFF_DELAYS:   delays_r   <= pwdata[15:0];
            `DCR_OFF_SPLICE:   splice_r   <= pwdata[15:0];
            `DCR_OFF_CYL:      cyl_r      <= pwdata;
            `DCR_OFF_HEADS:    heads_r    <= pwdata[15:0];
            `DCR_OFF_GAP_SYNC: gap_sync_r <= pwdata[15:0];
            `DCR_OFF_STWORDS:  stwords_r  <= pwdata[15:0];
            `DCR_OFF_SEEKSKEW: seekskew_r <= pwdata[15:0];
            `DCR_OFF_SECT:     sect_r     <= pwdata;
            `DCR_OFF_VENDOR: begin
               vendor_r <= pwdata[15:0];
               mod6_r   <= pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Rate in kHz, rounded up
   reg [31:0] rate_khz_r;
   reg [31:0] rate_q;
   always @* begin
      rate_q = rate_hz_r / `DCR_HZ_PER_KHZ;
      if (rate_hz_r != rate_q * `DCR_HZ_PER_KHZ)
         rate_q = rate_q + 32'd1;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rate_khz_r <= 32'h00000000;
      else
         rate_khz_r <= rate_q;
   end

   // Rate subscript valid when in range for the port
   wire rate_ok = HIGH_SPEED ?
                  ((rate_hz_r >= `DCR_RATE_MIN_HS_HZ) && (rate_hz_r <= `DCR_RATE_MAX_HZ)) :
                  (rate_hz_r <= `DCR_RATE_MAX_LS_HZ);

   ////////////////////////////////////////////////////////////////////
   // Link strobe synchroniser and edge detect
   reg        strb_s1_r;
   reg        strb_s2_r;
   reg        strb_s3_r;
   reg [15:0] cw_s1_r;
   reg [15:0] cw_s2_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strb_s1_r <= 1'b0;
         strb_s2_r <= 1'b0;
         strb_s3_r <= 1'b0;
         cw_s1_r   <= 16'h0000;
         cw_s2_r   <= 16'h0000;
      end else begin
         strb_s1_r <= cmd_strobe;
         strb_s2_r <= strb_s1_r;
         strb_s3_r <= strb_s2_r;
         cw_s1_r   <= cmd_word;
         cw_s2_r   <= cw_s1_r;
      end
   end
   wire strb_rise = strb_s2_r & ~strb_s3_r;
   wire apb_cmd   = apb_wr & (paddr == `DCR_OFF_CMD);
   wire take      = strb_rise | apb_cmd;
   wire [15:0] cw = apb_cmd ? pwdata[15:0] : cw_s2_r;
   wire [3:0]  md = cw[`DCR_MOD_HI:`DCR_MOD_LO];
   wire [7:0]  sb = cw[`DCR_SUB_HI:`DCR_SUB_LO];

   ////////////////////////////////////////////////////////////////////
   // Response decode
   always @* begin
      resp_nxt = 16'h0000;
      case (md)
         `DCR_MOD_GENERAL: begin
            case (sb)
               `DCR_SUB_RATE:     resp_nxt = rate_khz_r[15:0];
               `DCR_SUB_GRPSKEW:  resp_nxt = {8'h00, skew_r[7:0]};
               `DCR_SUB_DELAYS:   resp_nxt = delays_r;
               `DCR_SUB_MARKSKEW: resp_nxt = {8'h00, mark_skew_r[7:0]};
               `DCR_SUB_SPLICE:   resp_nxt = splice_r;
               default:           resp_nxt = 16'h0000;
            endcase
         end
         `DCR_MOD_FIX_CYL:   resp_nxt = cyl_r[15:0];
         `DCR_MOD_REM_CYL:   resp_nxt = cyl_r[31:16];
         `DCR_MOD_HEADS:     resp_nxt = heads_r;
         `DCR_MOD_UNF_BYTES: resp_nxt = sect_r[15:0];
         `DCR_MOD_SECTORS:   resp_nxt = sect_r[31:16];
         `DCR_MOD_SIX:       resp_nxt = mod6_r;
         `DCR_MOD_GAP:       resp_nxt = {gap_sync_r[15:8], 8'h00};
         `DCR_MOD_SYNC:      resp_nxt = {8'h00, gap_sync_r[7:0]};
         `DCR_MOD_STWORDS:   resp_nxt = stwords_r;
         `DCR_MOD_SEEKSKEW:  resp_nxt = seekskew_r;
         `DCR_MOD_VENDOR:    resp_nxt = vendor_r;
         default:            resp_nxt = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_word      <= 16'h0000;
         resp_valid     <= 1'b0;
         cmd_r          <= 32'h00000000;
         rate_supported <= 1'b0;
      end else begin
         resp_valid     <= take;
         rate_supported <= rate_ok;
         if (take) begin
            resp_word <= resp_nxt;
            cmd_r     <= {16'h0000, cw};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB read and answer, zero wait states
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel & ~penable) begin
            case (paddr)
               `DCR_OFF_CMD:      prdata <= cmd_r;
               `DCR_OFF_RESP:     prdata <= {16'h0000, resp_word};
               `DCR_OFF_STATUS:   prdata <= {31'h00000000, rate_ok};
               `DCR_OFF_RATE_HZ:  prdata <= rate_hz_r;
               `DCR_OFF_SKEW:     prdata <= {8'h00, mark_skew_r[7:0], 8'h00, skew_r[7:0]};
               `DCR_OFF_DELAYS:   prdata <= {16'h0000, delays_r};
               `DCR_OFF_SPLICE:   prdata <= {16'h0000, splice_r};
               `DCR_OFF_CYL:      prdata <= cyl_r;
               `DCR_OFF_HEADS:    prdata <= {16'h0000, heads_r};
               `DCR_OFF_GAP_SYNC: prdata <= {16'h0000, gap_sync_r};
               `DCR_OFF_STWORDS:  prdata <= {16'h0000, stwords_r};
               `DCR_OFF_SEEKSKEW: prdata <= {16'h0000, seekskew_r};
               `DCR_OFF_SECT:     prdata <= sect_r;
               `DCR_OFF_VENDOR:   prdata <= {mod6_r, vendor_r};
               default:           pslverr <= ~pwrite;
            endcase
            if (pwrite && paddr > `DCR_OFF_VENDOR)
               pslverr <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ### verification/dcr_config_resp_sva.sv
// Checker for the configuration responder, ports only.
// Assumes a bind onto dcr_config_resp; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module dcr_config_resp_sva #(
   parameter HIGH_SPEED = 1'b1
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Link
   input wire logic        cmd_strobe,
   input wire logic [15:0] cmd_word,
   input wire logic [15:0] resp_word,
   input wire logic        resp_valid,
   input wire logic        rate_supported
);
   logic [15:0] cmd_r;
   logic        stb_r;
   // Last command, from either source
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= 16'h0000;
         stb_r <= 1'b0;
      end else begin
         stb_r <= cmd_strobe;
         if (cmd_strobe && !stb_r)
            cmd_r <= cmd_word;
         if (psel && penable && pwrite && pready && paddr == 12'h000)
            cmd_r <= pwdata[15:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rise;
      !cmd_strobe ##1 cmd_strobe;
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   AST_TAKE: assert property (s_rise |-> ##[3:5] resp_valid)
      else $error("no response after strobe");
   AST_VALID_PULSE: assert property (resp_valid |=> !resp_valid)
      else $error("response valid too long");
   AST_HOLD: assert property (!resp_valid |-> $stable(resp_word))
      else $error("response word moved");
   AST_RESERVED: assert property (resp_valid && cmd_r[11:8] inside {[4'ha:4'hd]}
      |-> resp_word == 16'h0000)
      else $error("reserved modifier not zero");
   AST_SYNC_HI: assert property (resp_valid && cmd_r[11:8] == 4'h8
      |-> resp_word[15:8] == 8'h00)
      else $error("sync word upper byte set");
   AST_SUB_HI: assert property (resp_valid && cmd_r[11:0] inside {12'h00a, 12'h00c}
      |-> resp_word[15:8] == 8'h00)
      else $error("skew word upper byte set");
   AST_GAP_LO: assert property (resp_valid && cmd_r[11:8] == 4'h7
      |-> resp_word[7:0] == 8'h00)
      else $error("gap word lower byte set");
   AST_ANSWER: assert property (s_setup |=> pready ##1 !pready)
      else $error("bus answer late");
   AST_NO_STRAY: assert property (!(psel && !penable) |=> !pready)
      else $error("stray ready");
   AST_UNMAPPED: assert property (s_setup and paddr > 12'h034
      |=> pslverr && prdata == 32'h0)
      else $error("unmapped access accepted");
endmodule
`default_nettype wire

// ### verification/dcr_ctrl_model.sv
// Controller model: sends configuration commands on the link.
// Assumes the bench calls send; link clock runs only inside a frame.
`timescale 1ns/100ps
`default_nettype none
module dcr_ctrl_model (
   // Link command
   output var logic        cmd_strobe,
   output var logic [15:0] cmd_word
);
   // Values the controller falls back on when the drive returns none
   localparam int RG_WINDOW_DFLT = 16;
   localparam int SPLICE_DFLT    = 7;
   localparam int RD_DELAY_DFLT  = 9;
   localparam int WR_DELAY_DFLT  = 8;
   localparam int MARK_SKEW_DFLT = 0;
   // No rate answer means low speed port
   localparam bit LOW_SPEED_DFLT = 1'b1;
   logic lclk;
   initial begin
      lclk = 1'b0;
      cmd_strobe = 1'b0;
      cmd_word = 16'hffff;
   end
   task automatic tick;
      #80 lclk = 1'b1;
      #80 lclk = 1'b0;
   endtask
   // Word stable around strobe, scrambled once released
   task automatic send(input logic [15:0] w);
      #3 cmd_word = w;
      tick();
      cmd_strobe = 1'b1;
      tick();
      cmd_strobe = 1'b0;
      tick();
      cmd_word = ~w;
   endtask
endmodule
`default_nettype wire

// ### verification/disk_config_response_bench.sv
// Bench: programs the responder over APB and requests words.
// Assumes the controller model drives the link side.
`timescale 1ns/100ps
`default_nettype none
module disk_config_response_bench;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic        resp_valid, rate_supported, cmd_strobe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] cmd_word, resp_word;
   int          error_cnt, tests_run, cyc;
   logic [11:0] radr [8] = '{12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024,
                             12'h028, 12'h02c};
   logic [31:0] rdat [8] = '{32'h005a00c3, 32'h0908, 32'h1007, 32'h02000400, 32'h0204,
                             32'h1b0c, 32'h0301, 32'h4d05};
   logic [15:0] cmds [16] = '{16'h00a, 16'h00c, 16'h00b, 16'h00d, 16'h100, 16'h200,
      16'h300, 16'h700, 16'h800, 16'h900, 16'he00, 16'ha00, 16'hb00, 16'hc00, 16'hd00,
      16'h00e};
   logic [15:0] exps [16] = '{16'h00c3, 16'h005a, 16'h0908, 16'h1007, 16'h0400,
      16'h0200, 16'h0204, 16'h1b00, 16'h000c, 16'h0301, 16'h4d05, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0};
   dcr_config_resp #(.HIGH_SPEED(1'b1)) dcr_config_resp_inst (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_strobe(cmd_strobe),
      .cmd_word(cmd_word), .resp_word(resp_word), .resp_valid(resp_valid),
      .rate_supported(rate_supported));
   dcr_ctrl_model dcr_ctrl_model_inst (.cmd_strobe(cmd_strobe), .cmd_word(cmd_word));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge clk);
      end
      if (n == 40)
         error_cnt++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_resp(input logic [15:0] exp);
      int n;
      n = 0;
      while (resp_valid !== 1'b1 && n < 200) begin
         n++;
         @(posedge clk);
      end
      if (n == 200)
         error_cnt++;
      chk({16'h0, resp_word}, {16'h0, exp});
   endtask
   // Command over the link or through the command register
   task automatic issue(input logic [15:0] c, input logic [15:0] exp, input logic link);
      if (link)
         fork
            dcr_ctrl_model_inst.send(c);
            wait_resp(exp);
         join
      else
         fork
            apb(1'b1, 12'h000, {16'h0, c});
            wait_resp(exp);
         join
      apb(1'b0, 12'h004, 32'h0);
      chk(q, {16'h0, exp});
   endtask
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         apb(1'b1, radr[i], rdat[i]);
      apb(1'b0, 12'h010, 32'h0);
      chk(q, 32'h005a00c3);
      apb(1'b0, 12'h038, 32'h0);
      chk({q[31:1], e}, 32'h1);
      $display("Test registers done");
      for (int i = 0; i < 16; i++)
         issue(cmds[i], exps[i], i[0]);
      apb(1'b1, 12'h030, 32'h00200258);
      apb(1'b1, 12'h034, 32'h00110022);
      issue(16'h0400, 16'h0258, 1'b0);
      issue(16'h0500, 16'h0020, 1'b1);
      issue(16'h0600, 16'h0011, 1'b0);
      issue(16'h0f00, 16'h0022, 1'b1);
      apb(1'b0, 12'h000, 32'h0);
      chk(q, 32'h00000f00);
      $display("Test commands done");
      apb(1'b1, 12'h00c, 32'd10000000);
      issue(16'h0008, 16'd10000, 1'b1);
      apb(1'b1, 12'h00c, 32'd15000500);
      issue(16'h0008, 16'd15001, 1'b0);
      apb(1'b1, 12'h00c, 32'd25000000);
      apb(1'b0, 12'h008, 32'h0);
      chk({30'h0, q[0], rate_supported}, 32'h0);
      apb(1'b1, 12'h00c, 32'd24000000);
      apb(1'b0, 12'h008, 32'h0);
      chk({30'h0, q[0], rate_supported}, 32'h3);
      apb(1'b1, 12'h00c, 32'd9999999);
      apb(1'b0, 12'h008, 32'h0);
      chk({30'h0, q[0], rate_supported}, 32'h0);
      $display("Test rate done");
      end_of_test();
   end
endmodule
bind dcr_config_resp dcr_config_resp_sva #(.HIGH_SPEED(HIGH_SPEED)) dcr_config_resp_sva_inst (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmd_strobe(cmd_strobe), .cmd_word(cmd_word), .resp_word(resp_word),
   .resp_valid(resp_valid), .rate_supported(rate_supported));
`default_nettype wire
